// ---- design/scd_pkg.sv ----
// Constants, code tables, carriers and helpers for the special-character codec.
// Assumes 10-bit transmission characters ordered abcdei fghj, bit a at bit 9.
package scd_pkg;

  // Register byte offsets
  localparam logic [11:0] SCD_OFF_CTRL = 12'h000;
  localparam logic [11:0] SCD_OFF_STATUS = 12'h004;
  localparam logic [11:0] SCD_OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] SCD_OFF_IRQ_MASK = 12'h00C;

  // Field positions
  localparam int SCD_CTRL_FREN_BIT = 0;
  localparam int SCD_CTRL_MARK_LSB = 4;
  localparam int SCD_ST_TX_RD_BIT = 0;
  localparam int SCD_ST_RX_RD_BIT = 1;
  localparam int SCD_ST_LOCK_BIT = 2;
  localparam int SCD_ST_PEND_BIT = 3;
  localparam int SCD_ST_OFF_LSB = 8;
  localparam int SCD_IRQ_W = 5;
  localparam int SCD_IRQ_CODE_BIT = 0;
  localparam int SCD_IRQ_DISP_BIT = 1;
  localparam int SCD_IRQ_CTL_BIT = 2;
  localparam int SCD_IRQ_ALIGN_BIT = 3;
  localparam int SCD_IRQ_RESV_BIT = 4;

  // Reset values
  localparam logic SCD_FREN_RST = 1'b1;
  localparam logic [3:0] SCD_MARK_RST = 4'h1;
  localparam logic [4:0] SCD_IRQ_MASK_RST = 5'h00;

  // Special codes as seen on the host byte
  localparam logic [7:0] SCD_C_EOF = 8'h22;
  localparam logic [7:0] SCD_C_VIOL = 8'hE0;
  localparam logic [7:0] SCD_C_NEGK = 8'hE1;
  localparam logic [7:0] SCD_C_POSK = 8'hE2;
  localparam logic [7:0] SCD_C_RDERR = 8'hE4;

  // Negative-disparity forms; positive forms are the bitwise complement, but balanced data blocks other than D7 and .3 have one form
  localparam logic [9:0] SCD_K285_NEG = 10'h0FA;
  localparam logic [9:0] SCD_C07_NEG = 10'h278;
  localparam logic [9:0] SCD_C47_NEG = 10'h375;
  localparam int SCD_NUM_K = 12;
  localparam logic [3:0] SCD_K285_IDX = 4'h5;
  localparam logic [9:0] SCD_KT [SCD_NUM_K] = '{10'h0F4, 10'h0F9, 10'h0F5, 10'h0F3,
    10'h0F2, 10'h0FA, 10'h0F6, 10'h0F8, 10'h3A8, 10'h368, 10'h2E8, 10'h1E8};
  localparam logic [5:0] SCD_T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29,
    6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B,
    6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36,
    6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] SCD_T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] SCD_A7 = 4'h7;

  typedef enum logic {SCD_FR_HUNT = 1'b0, SCD_FR_LOCK = 1'b1} scd_frame_e;

  typedef struct packed {
    logic valid;
    logic special_select;
    logic violation_send;
    logic cell_start;
    logic [7:0] data;
  } scd_tx_req_s;

  typedef struct packed {
    logic valid;
    logic special_flag;
    logic violation_flag;
    logic cell_start_flag;
    logic [7:0] data;
  } scd_rx_ind_s;

  // Running disparity after a character, 1 = positive
  function automatic logic scd_rd_after(input logic rd, input logic [9:0] ch);
    int n6;
    int n4;
    logic m;
    n6 = $countones(ch[9:4]);
    n4 = $countones(ch[3:0]);
    m = (n6 > 3) ? 1'b1 : ((n6 < 3) ? 1'b0 : rd);
    return (n4 > 2) ? 1'b1 : ((n4 < 2) ? 1'b0 : m);
  endfunction

  function automatic logic [9:0] scd_by_rd(input logic [9:0] neg, input logic rd);
    return rd ? ~neg : neg;
  endfunction

endpackage

// ---- design/scd_enc.sv ----
// Data character 8B/10B encoder, combinational.
// Assumes the caller holds running disparity and updates it.
`timescale 1ns/1ps
module scd_enc
  import scd_pkg::*;
(
  input wire logic [7:0] data_in,
  input wire logic rd_in,
  output logic [9:0] code_out
);

  logic [4:0] x;
  logic [2:0] y;
  logic [5:0] six;
  logic [3:0] four;
  logic rd_mid;
  logic alt;

  always_comb
  begin
    x = data_in[4:0];
    y = data_in[7:5];
    six = SCD_T6[x];
    if (rd_in && (($countones(six) != 3) || (x == 5'd7)))
    begin
      six = ~six;
    end
    rd_mid = ($countones(six) == 3) ? rd_in : ($countones(six) > 3);
    // Alternate .7 avoids a run of five equal bits
    alt = (y == 3'd7) && ((!rd_mid && ((x == 5'd17) || (x == 5'd18) || (x == 5'd20))) ||
          (rd_mid && ((x == 5'd11) || (x == 5'd13) || (x == 5'd14))));
    four = alt ? SCD_A7 : SCD_T4[y];
    if (rd_mid && (($countones(four) != 2) || (y == 3'd3) || (y == 3'd7)))
    begin
      four = ~four;
    end
    code_out = {six, four};
  end

endmodule // scd_enc

// ---- design/scd_codec.sv ----
// Special-character encode and decode around an 8B/10B link, with APB registers.
// Assumes one transmission character per clock each way and a synchronous host.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Special meaning applies when transmit select or receive special flag is high.
// - C4.7 sends the disparity violation pattern chosen by current disparity.
// - Received control characters other than K28.5 at correct disparity are discarded and raise cell-start plus special flags.
// - Receiver aligns character framing on K28.5 in the incoming stream.
// - Without user data the transmitter sends K28.5 fill.
// - Received fill K28.5 is dropped and never written onward.
// - C2.1 sends K28.5 in the form chosen by running disparity.
// - C0.7 sends a code violation, same as asserting violation-send.
// - Receiver reports C0.7 only for characters found in no table.
// - C1.7 sends negative K28.5 regardless of disparity.
// - Negative K28.5 at positive disparity decodes to C1.7, else handled normally.
// - C2.7 sends positive K28.5 regardless of disparity.
// - Positive K28.5 at negative disparity decodes to C2.7, else handled normally.
// - Valid characters other than K28.5 with wrong disparity decode to C4.7.
module scd_codec
  import scd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic apb_psel_in,
  input wire logic apb_penable_in,
  input wire logic apb_pwrite_in,
  input wire logic [11:0] apb_paddr_in,
  input wire logic [31:0] apb_pwdata_in,
  output logic [31:0] apb_prdata_out,
  output logic apb_pready_out,
  output logic apb_pslverr_out,
  output logic irq_out,
  input wire scd_tx_req_s tx_req_in,
  output logic [9:0] tx_char_out,
  input wire logic rx_word_valid_in,
  input wire logic [9:0] rx_word_in,
  output scd_rx_ind_s rx_ind_out
);

  logic [9:0] tx_char_r, tx_char_nxt, tx_enc_code;
  logic rd_tx_r, rd_tx_nxt, lsb_pend_r, lsb_pend_nxt, ev_resv;
  logic [7:0] tx_enc_data;
  logic [3:0] mark_idx;
  logic [9:0] rx_prev_r, rx_prev_nxt, cand, rx_char, rx_reenc;
  logic [19:0] win;
  logic [3:0] off_r, off_nxt, comma_pos, off_use, k_idx;
  logic comma_hit, k_hit, k_pos, x_hit, y_hit, d_ok, rx_proc;
  logic [4:0] x_val;
  logic [2:0] y_val;
  logic rd_rx_r, rd_rx_nxt;
  scd_frame_e fr_state_r, fr_state_nxt;
  scd_rx_ind_s ind_r, ind_nxt;
  logic ev_code, ev_disp, ev_ctl, ev_align;
  logic fren_r, fren_nxt;
  logic [3:0] mark_r, mark_nxt;
  logic [4:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, ev_vec;
  logic [31:0] prdata_r, prdata_nxt, rmux;
  logic addr_ok, apb_access, apb_wr;

  scd_enc u_tx_enc (
    .data_in(tx_enc_data),
    .rd_in(rd_tx_r),
    .code_out(tx_enc_code)
  );

  scd_enc u_rx_enc (
    .data_in({y_val, x_val}),
    .rd_in(rd_rx_r),
    .code_out(rx_reenc)
  );

  // Transmit character selection
  always_comb
  begin
    mark_idx = (mark_r < 4'(SCD_NUM_K)) ? mark_r : 4'h0;
    tx_enc_data = tx_req_in.data;
    if (lsb_pend_r)
    begin
      tx_enc_data[0] = ~rd_tx_r;
    end
    tx_char_nxt = scd_by_rd(SCD_K285_NEG, rd_tx_r);
    lsb_pend_nxt = lsb_pend_r;
    ev_resv = 1'b0;
    if (tx_req_in.valid)
    begin
      lsb_pend_nxt = 1'b0;
      if (tx_req_in.special_select)
      begin
        case (tx_req_in.data)
          SCD_C_EOF:
          begin
            tx_char_nxt = scd_by_rd(SCD_K285_NEG, rd_tx_r);
            lsb_pend_nxt = 1'b1;
          end
          SCD_C_VIOL: tx_char_nxt = scd_by_rd(SCD_C07_NEG, rd_tx_r);
          SCD_C_NEGK: tx_char_nxt = SCD_K285_NEG;
          SCD_C_POSK: tx_char_nxt = ~SCD_K285_NEG;
          SCD_C_RDERR: tx_char_nxt = scd_by_rd(SCD_C47_NEG, rd_tx_r);
          default:
          begin
            if ((tx_req_in.data[7:4] == 4'h0) && (tx_req_in.data[3:0] < 4'(SCD_NUM_K)))
            begin
              tx_char_nxt = scd_by_rd(SCD_KT[tx_req_in.data[3:0]], rd_tx_r);
            end
            else
            begin
              // Reserved code goes out as a violation and is flagged
              tx_char_nxt = scd_by_rd(SCD_C07_NEG, rd_tx_r);
              ev_resv = 1'b1;
            end
          end
        endcase
      end
      else if (tx_req_in.violation_send)
      begin
        tx_char_nxt = scd_by_rd(SCD_C07_NEG, rd_tx_r);
      end
      else if (tx_req_in.cell_start)
      begin
        tx_char_nxt = scd_by_rd(SCD_KT[mark_idx], rd_tx_r);
      end
      else
      begin
        tx_char_nxt = tx_enc_code;
      end
    end
    rd_tx_nxt = scd_rd_after(rd_tx_r, tx_char_nxt);
  end

  // Receive framing and decode
  always_comb
  begin
    win = {rx_prev_r, rx_word_in};
    cand = '0;
    comma_hit = 1'b0;
    comma_pos = off_r;
    for (int k = 9; k >= 0; k--)
    begin
      cand = 10'(win >> (10 - k));
      if (rx_word_valid_in && fren_r && ((cand == SCD_K285_NEG) || (cand == ~SCD_K285_NEG)))
      begin
        comma_hit = 1'b1;
        comma_pos = 4'(k);
      end
    end
    off_use = comma_hit ? comma_pos : off_r;
    rx_char = 10'(win >> (4'd10 - off_use));
    k_hit = 1'b0;
    k_pos = 1'b0;
    k_idx = 4'h0;
    for (int i = 0; i < SCD_NUM_K; i++)
    begin
      if ((rx_char == SCD_KT[i]) || (rx_char == ~SCD_KT[i]))
      begin
        k_hit = 1'b1;
        k_idx = 4'(i);
        k_pos = (rx_char != SCD_KT[i]);
      end
    end
    x_hit = 1'b0;
    x_val = 5'h00;
    for (int x = 0; x < 32; x++)
    begin
      // A balanced block other than D7 has one form; its complement is another code
      if ((rx_char[9:4] == SCD_T6[x]) || ((rx_char[9:4] == ~SCD_T6[x]) &&
          (($countones(SCD_T6[x]) != 3) || (x == 7))))
      begin
        x_hit = 1'b1;
        x_val = 5'(x);
      end
    end
    y_hit = (rx_char[3:0] == SCD_A7) || (rx_char[3:0] == ~SCD_A7);
    y_val = y_hit ? 3'd7 : 3'd0;
    for (int y = 0; y < 8; y++)
    begin
      if ((rx_char[3:0] == SCD_T4[y]) || ((rx_char[3:0] == ~SCD_T4[y]) &&
          (($countones(SCD_T4[y]) != 2) || (y == 3) || (y == 7))))
      begin
        y_hit = 1'b1;
        y_val = 3'(y);
      end
    end
    d_ok = x_hit && y_hit;
    rx_proc = rx_word_valid_in && ((fr_state_r == SCD_FR_LOCK) || comma_hit);
    ind_nxt = '0;
    ev_code = 1'b0;
    ev_disp = 1'b0;
    ev_ctl = 1'b0;
    if (rx_proc)
    begin
      if (k_hit && (k_idx == SCD_K285_IDX))
      begin
        if (k_pos != rd_rx_r)
        begin
          ind_nxt.valid = 1'b1;
          ind_nxt.special_flag = 1'b1;
          ind_nxt.data = k_pos ? SCD_C_POSK : SCD_C_NEGK;
        end
      end
      else if (k_hit && (k_pos == rd_rx_r))
      begin
        ind_nxt.cell_start_flag = 1'b1;
        ind_nxt.special_flag = 1'b1;
        ind_nxt.data = {4'h0, k_idx};
        ev_ctl = 1'b1;
      end
      else if (d_ok && (rx_reenc == rx_char))
      begin
        ind_nxt.valid = 1'b1;
        ind_nxt.data = {y_val, x_val};
      end
      else if (k_hit || d_ok)
      begin
        ind_nxt.valid = 1'b1;
        ind_nxt.special_flag = 1'b1;
        ind_nxt.violation_flag = 1'b1;
        ind_nxt.data = SCD_C_RDERR;
        ev_disp = 1'b1;
      end
      else
      begin
        ind_nxt.valid = 1'b1;
        ind_nxt.special_flag = 1'b1;
        ind_nxt.violation_flag = 1'b1;
        ind_nxt.data = SCD_C_VIOL;
        ev_code = 1'b1;
      end
    end
    rd_rx_nxt = rx_proc ? scd_rd_after(rd_rx_r, rx_char) : rd_rx_r;
    rx_prev_nxt = rx_word_valid_in ? rx_word_in : rx_prev_r;
    off_nxt = rx_word_valid_in ? off_use : off_r;
    ev_align = comma_hit && ((comma_pos != off_r) || (fr_state_r == SCD_FR_HUNT));
    case (fr_state_r)
      SCD_FR_HUNT: fr_state_nxt = (comma_hit || !fren_r) ? SCD_FR_LOCK : SCD_FR_HUNT;
      SCD_FR_LOCK: fr_state_nxt = SCD_FR_LOCK;
      default: fr_state_nxt = SCD_FR_HUNT;
    endcase
  end

  // APB registers and interrupt status
  always_comb
  begin
    addr_ok = (apb_paddr_in == SCD_OFF_CTRL) || (apb_paddr_in == SCD_OFF_STATUS) ||
              (apb_paddr_in == SCD_OFF_IRQ_STAT) || (apb_paddr_in == SCD_OFF_IRQ_MASK);
    apb_access = apb_psel_in && apb_penable_in;
    apb_wr = apb_access && apb_pwrite_in && addr_ok;
    rmux = '0;
    case (apb_paddr_in)
      SCD_OFF_CTRL:
      begin
        rmux[SCD_CTRL_FREN_BIT] = fren_r;
        rmux[SCD_CTRL_MARK_LSB +: 4] = mark_r;
      end
      SCD_OFF_STATUS:
      begin
        rmux[SCD_ST_TX_RD_BIT] = rd_tx_r;
        rmux[SCD_ST_RX_RD_BIT] = rd_rx_r;
        rmux[SCD_ST_LOCK_BIT] = (fr_state_r == SCD_FR_LOCK);
        rmux[SCD_ST_PEND_BIT] = lsb_pend_r;
        rmux[SCD_ST_OFF_LSB +: 4] = off_r;
      end
      SCD_OFF_IRQ_STAT: rmux[SCD_IRQ_W-1:0] = irq_stat_r;
      SCD_OFF_IRQ_MASK: rmux[SCD_IRQ_W-1:0] = irq_mask_r;
      default: rmux = '0;
    endcase
    prdata_nxt = (apb_psel_in && !apb_penable_in) ? rmux : prdata_r;
    fren_nxt = fren_r;
    mark_nxt = mark_r;
    irq_mask_nxt = irq_mask_r;
    ev_vec = '0;
    ev_vec[SCD_IRQ_CODE_BIT] = ev_code;
    ev_vec[SCD_IRQ_DISP_BIT] = ev_disp;
    ev_vec[SCD_IRQ_CTL_BIT] = ev_ctl;
    ev_vec[SCD_IRQ_ALIGN_BIT] = ev_align;
    ev_vec[SCD_IRQ_RESV_BIT] = ev_resv;
    irq_stat_nxt = irq_stat_r;
    if (apb_wr && (apb_paddr_in == SCD_OFF_CTRL))
    begin
      fren_nxt = apb_pwdata_in[SCD_CTRL_FREN_BIT];
      mark_nxt = apb_pwdata_in[SCD_CTRL_MARK_LSB +: 4];
    end
    if (apb_wr && (apb_paddr_in == SCD_OFF_IRQ_MASK))
    begin
      irq_mask_nxt = apb_pwdata_in[SCD_IRQ_W-1:0];
    end
    if (apb_wr && (apb_paddr_in == SCD_OFF_IRQ_STAT))
    begin
      irq_stat_nxt = irq_stat_r & ~apb_pwdata_in[SCD_IRQ_W-1:0];
    end
    // New events win over a same-cycle clear
    irq_stat_nxt = irq_stat_nxt | ev_vec;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_char_r <= SCD_K285_NEG;
      rd_tx_r <= 1'b0;
      lsb_pend_r <= 1'b0;
      rx_prev_r <= '0;
      off_r <= '0;
      rd_rx_r <= 1'b0;
      fr_state_r <= SCD_FR_HUNT;
      ind_r <= '0;
      fren_r <= SCD_FREN_RST;
      mark_r <= SCD_MARK_RST;
      irq_stat_r <= '0;
      irq_mask_r <= SCD_IRQ_MASK_RST;
      prdata_r <= '0;
    end
    else
    begin
      tx_char_r <= tx_char_nxt;
      rd_tx_r <= rd_tx_nxt;
      lsb_pend_r <= lsb_pend_nxt;
      rx_prev_r <= rx_prev_nxt;
      off_r <= off_nxt;
      rd_rx_r <= rd_rx_nxt;
      fr_state_r <= fr_state_nxt;
      ind_r <= ind_nxt;
      fren_r <= fren_nxt;
      mark_r <= mark_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign tx_char_out = tx_char_r;
  assign rx_ind_out = ind_r;
  assign apb_prdata_out = prdata_r;
  assign apb_pready_out = 1'b1;
  assign apb_pslverr_out = apb_access && !addr_ok;
  assign irq_out = |(irq_stat_r & irq_mask_r);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_tx_fill_k: assert property (!tx_req_in.valid |=>
    tx_char_r == ($past(rd_tx_r) ? ~SCD_K285_NEG : SCD_K285_NEG)) else $error("bad fill");
  a_tx_rd_err: assert property (tx_req_in.valid && tx_req_in.special_select &&
    tx_req_in.data == SCD_C_RDERR |=> tx_char_r == ($past(rd_tx_r) ? ~SCD_C47_NEG : SCD_C47_NEG))
    else $error("bad disparity violation pattern");
  a_tx_neg_k: assert property (tx_req_in.valid && tx_req_in.special_select &&
    tx_req_in.data == SCD_C_NEGK |=> tx_char_r == SCD_K285_NEG) else $error("bad neg K");
  a_tx_pos_k: assert property (tx_req_in.valid && tx_req_in.special_select &&
    tx_req_in.data == SCD_C_POSK |=> tx_char_r == ~SCD_K285_NEG) else $error("bad pos K");
  a_tx_eof_k: assert property (tx_req_in.valid && tx_req_in.special_select &&
    tx_req_in.data == SCD_C_EOF |=> lsb_pend_r && rd_tx_r != $past(rd_tx_r) &&
    tx_char_r == ($past(rd_tx_r) ? ~SCD_K285_NEG : SCD_K285_NEG)) else $error("bad eof K");
  a_tx_lsb_force: assert property (lsb_pend_r && tx_req_in.valid |->
    tx_enc_data[0] == !rd_tx_r ##1 lsb_pend_r == ($past(tx_req_in.special_select) &&
    $past(tx_req_in.data) == SCD_C_EOF)) else $error("bad forced lsb");
  a_tx_viol_send: assert property (tx_req_in.valid && !tx_req_in.special_select &&
    tx_req_in.violation_send |=> (tx_char_r == SCD_C07_NEG) || (tx_char_r == ~SCD_C07_NEG))
    else $error("bad violation send");
  a_rx_fill_drop: assert property (rx_proc && k_hit && k_idx == SCD_K285_IDX &&
    k_pos == rd_rx_r |=> !ind_r.valid) else $error("fill not dropped");
  a_rx_neg_k: assert property (rx_proc && k_hit && k_idx == SCD_K285_IDX &&
    !k_pos && rd_rx_r |=> ind_r.valid && ind_r.data == SCD_C_NEGK) else $error("no C1.7");
  a_rx_pos_k: assert property (rx_proc && k_hit && k_idx == SCD_K285_IDX &&
    k_pos && !rd_rx_r |=> ind_r.valid && ind_r.data == SCD_C_POSK) else $error("no C2.7");
  a_rx_ctrl_drop: assert property (ind_r.cell_start_flag |->
    !ind_r.valid && ind_r.special_flag && $past(k_hit)) else $error("bad control flags");
  a_rx_code_err: assert property (ind_r.valid && ind_r.special_flag &&
    ind_r.data == SCD_C_VIOL |-> !$past(d_ok) && !$past(k_hit)) else $error("false code error");
  a_rx_disp_err: assert property (ind_r.valid && ind_r.special_flag &&
    ind_r.data == SCD_C_RDERR |-> $past(d_ok) || $past(k_hit)) else $error("false disparity error");
  a_rx_frame_lock: assert property (comma_hit |=>
    off_r == $past(comma_pos) && fr_state_r == SCD_FR_LOCK) else $error("framing not taken");
  a_rd_reset_neg: assert property ($fell(rst_in) |-> !rd_tx_r && !rd_rx_r)
    else $error("disparity not negative after reset");

  c_tx_fill: cover property (!tx_req_in.valid ##1 !tx_req_in.valid);
  c_tx_eof_data: cover property (tx_req_in.valid && tx_req_in.special_select &&
    tx_req_in.data == SCD_C_EOF ##1 lsb_pend_r && tx_req_in.valid);
  c_rx_code_err: cover property (ev_code);
  c_rx_lock: cover property (fr_state_r == SCD_FR_HUNT ##1 fr_state_r == SCD_FR_LOCK);

endmodule // scd_codec

// ---- tb/scd_remote.sv ----
// Remote transceiver model: streams 10-bit words into the receive side.
// Assumes bench commands change just after a rising edge of clk_in.
`timescale 1ns/1ps
module scd_remote
  import scd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic send_in,
  input wire logic [1:0] form_in,
  input wire logic [9:0] word_in,
  output logic rd_out,
  output logic rx_word_valid_out,
  output logic [9:0] rx_word_out
);
  logic [9:0] w;
  function automatic logic rd_next(input logic rd, input logic [9:0] c);
    logic m;
    m = ($countones(c[9:4]) == 3) ? rd : ($countones(c[9:4]) > 3);
    return ($countones(c[3:0]) == 2) ? m : ($countones(c[3:0]) > 2);
  endfunction
  // Form 0 follows disparity, 1 sends the word as given, 2 sends the wrong form
  always_comb
  begin
    w = send_in ? word_in : SCD_K285_NEG;
    if (!send_in || form_in == 2'h0)
      w = rd_out ? ~w : w;
    else if (form_in == 2'h2)
      w = rd_out ? w : ~w;
  end
  always_ff @(posedge clk_in)
  begin
    rx_word_valid_out <= !rst_in;
    rx_word_out <= w;
    rd_out <= rst_in ? 1'b0 : rd_next(rd_out, w);
  end
endmodule // scd_remote

// ---- tb/tb_scd_codec.sv ----
// Bench for the special-character codec: transmit table, receive cases, registers.
// Assumes the remote model supplies every receive word.
`timescale 1ns/1ps
module tb_scd_codec
  import scd_pkg::*;
;
  typedef struct packed {logic [11:0] req; logic [9:0] neg; logic byrd;} scd_tb_row_s;
  localparam scd_tb_row_s rows [19] = '{
    {12'h000, SCD_K285_NEG, 1'b1}, {12'h000, SCD_K285_NEG, 1'b1},
    {12'hCE1, SCD_K285_NEG, 1'b0}, {12'hCE1, SCD_K285_NEG, 1'b0},
    {12'hCE2, 10'h305, 1'b0}, {12'hCE2, 10'h305, 1'b0},
    {12'hCE4, SCD_C47_NEG, 1'b1}, {12'hCE4, SCD_C47_NEG, 1'b1},
    {12'hCE0, SCD_C07_NEG, 1'b1}, {12'hAB5, SCD_C07_NEG, 1'b1},
    {12'h895, 10'h2AD, 1'b0},
    {12'hCE0, SCD_C07_NEG, 1'b1}, {12'hAB5, SCD_C07_NEG, 1'b1},
    {12'h8B5, 10'h2AA, 1'b0}, {12'hC22, SCD_K285_NEG, 1'b1},
    {12'h8B4, 10'h2AA, 1'b0}, {12'hC22, SCD_K285_NEG, 1'b1},
    {12'h8B5, 10'h0BA, 1'b0}, {12'h900, SCD_KT[1], 1'b1}};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  scd_tx_req_s tx_req = '0;
  scd_rx_ind_s rx_ind;
  logic [9:0] tx_char, rxw, pend_exp;
  logic rxv, prd, snd = 1'b0, tx_rd = 1'b0, pend_on = 1'b0;
  logic [1:0] form = 2'h0;
  logic [9:0] word = 10'h000;
  int n_errors = 0, comparisons = 0, cycles = 0;

  scd_codec dut (.clk_in(clk_in), .rst_in(rst_in), .apb_psel_in(psel),
    .apb_penable_in(pen), .apb_pwrite_in(pwr), .apb_paddr_in(paddr),
    .apb_pwdata_in(pwdata), .apb_prdata_out(prdata), .apb_pready_out(pready),
    .apb_pslverr_out(pslverr), .irq_out(irq), .tx_req_in(tx_req), .tx_char_out(tx_char),
    .rx_word_valid_in(rxv), .rx_word_in(rxw), .rx_ind_out(rx_ind));
  scd_remote remote (.clk_in(clk_in), .rst_in(rst_in), .send_in(snd), .form_in(form),
    .word_in(word), .rd_out(prd), .rx_word_valid_out(rxv), .rx_word_out(rxw));

  always #4 clk_in = ~clk_in;

  function automatic logic rd_next(input logic rd, input logic [9:0] c);
    logic m;
    m = ($countones(c[9:4]) == 3) ? rd : ($countones(c[9:4]) > 3);
    return ($countones(c[3:0]) == 2) ? m : ($countones(c[3:0]) > 2);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_in);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Drives one request and checks the character owed by the previous one
  task automatic tx_step(input logic [11:0] rq, input logic [9:0] neg, input logic byrd);
    @(posedge clk_in);
    tx_req <= scd_tx_req_s'(rq);
    #1;
    if (pend_on)
      chk({22'h0, tx_char}, {22'h0, pend_exp});
    pend_exp = (byrd && tx_rd) ? ~neg : neg;
    tx_rd = rd_next(tx_rd, pend_exp);
    pend_on = 1'b1;
  endtask

  task automatic rx_send(input logic [1:0] f, input logic [9:0] w, input logic [11:0] e,
    input logic k);
    int n;
    @(posedge clk_in);
    snd <= 1'b1;
    form <= f;
    word <= w;
    #1;
    if (k)
      e[7:0] = prd ? SCD_C_NEGK : SCD_C_POSK;
    @(posedge clk_in);
    snd <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (rx_ind[11:8] === 4'h0 && n < 8);
    chk({20'h0, rx_ind}, {20'h0, e});
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, SCD_OFF_CTRL, 32'h0);
    chk(rdat, 32'h11);
    apb(1'b0, SCD_OFF_IRQ_MASK, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    foreach (rows[i])
      tx_step(rows[i].req, rows[i].neg, rows[i].byrd);
    for (int n = 0; n < 12; n++)
      tx_step(12'hC00 | 12'(n), SCD_KT[n], 1'b1);
    // Balanced data held while the bus is busy keeps disparity fixed
    tx_step(12'h8B5, 10'h2AA, 1'b0);
    apb(1'b1, SCD_OFF_IRQ_STAT, 32'h1F);
    apb(1'b1, SCD_OFF_CTRL, 32'hB1);
    tx_step(12'h900, SCD_KT[11], 1'b1);
    tx_step(12'hCFF, SCD_C07_NEG, 1'b1);
    tx_step(12'h8B5, 10'h2AA, 1'b0);
    apb(1'b0, SCD_OFF_IRQ_STAT, 32'h0);
    chk(rdat, 32'h10);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, SCD_OFF_IRQ_MASK, 32'h10);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, SCD_OFF_IRQ_STAT, 32'h10);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h0);
    tx_step(12'h000, SCD_K285_NEG, 1'b1);
    apb(1'b0, SCD_OFF_STATUS, 32'h0);
    chk(rdat & 32'h4, 32'h4);
    rx_send(2'h1, 10'h2AA, 12'h8B5, 1'b0);
    rx_send(2'h1, 10'h15A, 12'h8AA, 1'b0);
    for (int n = 0; n < 12; n++)
      if (n != 5 && n != 7)
        rx_send(2'h0, SCD_KT[n], {8'h50, 4'(n)}, 1'b0);
    rx_send(2'h2, 10'h2AD, 12'hEE4, 1'b0);
    rx_send(2'h1, 10'h00F, 12'hEE0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      repeat (i) @(posedge clk_in);
      rx_send(2'h2, SCD_K285_NEG, 12'hC00, 1'b1);
    end
    rx_send(2'h0, SCD_K285_NEG, 12'h000, 1'b0);
    // Mid-run reset: fill starts from negative disparity, control register back to its reset value
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk({20'h0, rx_ind}, 32'h0);
    @(posedge clk_in);
    #1;
    chk({22'h0, tx_char}, {22'h0, SCD_K285_NEG});
    apb(1'b0, SCD_OFF_CTRL, 32'h0);
    chk(rdat, 32'h11);
    test_done();
  end
endmodule // tb_scd_codec
